// ### src/txpi_defs.svh
`ifndef TXPI_DEFS_SVH
`define TXPI_DEFS_SVH

// Register indices; byte address is four times the index
`define TXPI_IDX_KICK 8'h38
`define TXPI_IDX_MASK 8'h3c
`define TXPI_IDX_STATUS 8'h3e
`define TXPI_IDX_TXCFG 8'h40
`define TXPI_IDX_RXCFG 8'h44
`define TXPI_IDX_MISS 8'h4c
`define TXPI_IDX_TIMER 8'h5c

// Index field within haddr, and the bits above it that must be zero
`define TXPI_IDX_LSB 2
`define TXPI_IDX_MSB 9
`define TXPI_HIGH_LSB 10
`define TXPI_HIGH_ZERO 22'h000000

// Queue kick register fields
`define TXPI_KICK_HIGH 7
`define TXPI_KICK_NORMAL 6
`define TXPI_KICK_FORCED 0

// Event positions, shared by mask and status
`define TXPI_EV_FAULT 15
`define TXPI_EV_TIMEOUT 14
`define TXPI_EV_SOFT 8
`define TXPI_EV_TXDESC 7
`define TXPI_EV_OVERRUN 6
`define TXPI_EV_LINK 5
`define TXPI_EV_RXDESC 4
`define TXPI_EV_TXERR 3
`define TXPI_EV_TXOK 2
`define TXPI_EV_RXERR 1
`define TXPI_EV_RXOK 0
`define TXPI_EV_W 16
`define TXPI_EV_VALID 16'hc1ff
`define TXPI_EV_RST 16'h0000

// Own configuration fields
`define TXPI_RETRY_MSB 3
`define TXPI_RETRY_RST 4'h0
`define TXPI_ACC_RUNT 0
`define TXPI_ACC_CRC 1
`define TXPI_ACC_SHORT 2
`define TXPI_ACC_RST 3'h0
`define TXPI_TIMER_RST 32'h00000000

`endif

// ### src/txpi_pkg.sv
package txpi_pkg;

	typedef enum logic [3:0] {
		TXPI_IDLE = 4'b0001,
		TXPI_WRITE = 4'b0010,
		TXPI_READ_WAIT = 4'b0100,
		TXPI_READ_DONE = 4'b1000
	} txpi_bus_e;

endpackage

// ### src/txpi_miss_if.sv
`timescale 1ns/100ps

interface txpi_miss_if #(parameter int W = 32);
	logic drop;
	logic clear;
	logic [W-1:0] count;

	modport owner(output drop, output clear, input count);
	modport counter(input drop, input clear, output count);
endinterface

// ### src/txpi_miss_counter.sv
`timescale 1ns/100ps

module txpi_miss_counter #(
	parameter int W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	txpi_miss_if.counter miss
);

	// Saturates rather than wrapping so a flood never reads as a small count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miss.count <= '0;
		end else if (miss.clear) begin
			miss.count <= '0;
		end else if (miss.drop && !(&miss.count)) begin
			miss.count <= miss.count + 1'b1;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	miss_count_step_a: assert property (
		(miss.drop && !miss.clear && !(&miss.count))
		|=> miss.count == $past(miss.count) + 1'b1
	) else $error("missed packet count did not advance");

endmodule

// ### src/txpi_top.sv
`timescale 1ns/100ps
`include "txpi_defs.svh"

// Function
// - Writing one to high queue kick marks it pending until engine drains it.
// - Writing one to normal queue kick marks it pending until engine drains it.
// - Writing one to forced soft irq sets soft irq status, raising interrupt if mask bit 8 is set.
// - Forced soft irq stays set until soft irq status clears, then clears.
// - Mask has one enable per event; bits 13 to 9 reserved as zero.
// - Host bus fault sets status bit 15.
// - Timer equal to a nonzero compare value sets status bit 14.
// - Tx descriptor empty sets status bit 7.
// - Rx fifo overrun sets status bit 6.
// - Any change of link state sets status bit 5.
// - Rx descriptor empty sets status bit 4.
// - Each packet dropped after overrun increments missed packet counter, up to its all-ones ceiling.
// - Collisions reaching the retry limit abort transmit and set status bit 3.
// - Each good transmit completion sets status bit 2.
// - CRC or alignment error sets status bit 1; accept bits qualify CRC.
// - Each good receive completion sets status bit 0.
// - Writing one to a status bit clears it; zero leaves it.
module txpi_top #(
	parameter int MISS_W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	input wire logic high_queue_drained,
	input wire logic normal_queue_drained,
	output logic high_queue_kick,
	output logic normal_queue_kick,
	input wire logic host_bus_fault,
	input wire logic [31:0] free_running_timer,
	input wire logic tx_desc_empty,
	input wire logic rx_fifo_overrun,
	input wire logic rx_packet_dropped,
	input wire logic link_up,
	input wire logic rx_desc_empty,
	input wire logic tx_packet_start,
	input wire logic tx_collision,
	output logic tx_abort_error,
	input wire logic tx_done_good,
	input wire logic rx_frame_done,
	input wire logic rx_crc_error,
	input wire logic rx_align_error,
	input wire logic rx_runt,
	input wire logic rx_short,
	input wire logic rx_done_good
);

	if (MISS_W < 1 || MISS_W > 32) begin : g_bad_width
		$error("MISS_W must lie between 1 and 32");
	end
	function automatic logic is_idx(input logic [7:0] idx, input logic [7:0] target);
		is_idx = (idx == target);
	endfunction
	txpi_pkg::txpi_bus_e state;
	txpi_pkg::txpi_bus_e next_state;
	logic addr_ok;
	logic take;
	logic [7:0] cur_idx;
	logic cur_hit;
	logic wr_en;
	logic [31:0] rd_value;
	logic forced_soft_irq;
	logic [`TXPI_EV_W-1:0] interrupt_enable_mask;
	logic [`TXPI_EV_W-1:0] interrupt_event_status;
	logic [`TXPI_RETRY_MSB:0] tx_retry_setting;
	logic [`TXPI_ACC_SHORT:0] receive_config;
	logic [31:0] timer_compare_value;
	logic kick_wr;
	logic mask_wr;
	logic status_wr;
	logic soft_kick;
	logic [`TXPI_EV_W-1:0] ev;
	logic [`TXPI_EV_W-1:0] clr;
	logic link_s1;
	logic link_s2;
	logic link_s3;
	logic link_state;
	logic link_state_changed;
	logic timer_hit;
	logic crc_counts;
	logic rx_bad_frame;
	logic [8:0] coll_count;
	logic [8:0] coll_limit;
	txpi_miss_if #(.W(MISS_W)) miss_bus();
	txpi_miss_counter #(.W(MISS_W)) u_miss (
		.hclk(hclk),
		.hresetn(hresetn),
		.miss(miss_bus.counter)
	);

	// Bus slave: writes take no wait state, reads take one so that a read
	// right behind a write to the same register sees the written value
	assign take = hsel && hready && htrans[1];
	assign addr_ok = (haddr[31:`TXPI_HIGH_LSB] == `TXPI_HIGH_ZERO);

	always_comb begin
		next_state = txpi_pkg::TXPI_IDLE;
		case (state)
			txpi_pkg::TXPI_READ_WAIT: begin
				next_state = txpi_pkg::TXPI_READ_DONE;
			end
			txpi_pkg::TXPI_IDLE, txpi_pkg::TXPI_WRITE, txpi_pkg::TXPI_READ_DONE: begin
				if (take && hwrite) begin
					next_state = txpi_pkg::TXPI_WRITE;
				end else if (take) begin
					next_state = txpi_pkg::TXPI_READ_WAIT;
				end
			end
			default: begin
				next_state = txpi_pkg::TXPI_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= txpi_pkg::TXPI_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_idx <= 8'h00;
			cur_hit <= 1'b0;
		end else if (take) begin
			cur_idx <= haddr[`TXPI_IDX_MSB:`TXPI_IDX_LSB];
			cur_hit <= addr_ok;
		end
	end
	assign hreadyout = (state != txpi_pkg::TXPI_READ_WAIT);
	assign hresp = 1'b0;
	assign wr_en = (state == txpi_pkg::TXPI_WRITE) && cur_hit;
	assign kick_wr = wr_en && is_idx(cur_idx, `TXPI_IDX_KICK);
	assign mask_wr = wr_en && is_idx(cur_idx, `TXPI_IDX_MASK);
	assign status_wr = wr_en && is_idx(cur_idx, `TXPI_IDX_STATUS);
	assign miss_bus.clear = wr_en && is_idx(cur_idx, `TXPI_IDX_MISS);
	assign miss_bus.drop = rx_packet_dropped;
	// Unmapped words read as zero and ignore writes
	always_comb begin
		rd_value = 32'h00000000;
		if (cur_hit) begin
			if (is_idx(cur_idx, `TXPI_IDX_KICK)) begin
				rd_value[`TXPI_KICK_HIGH] = high_queue_kick;
				rd_value[`TXPI_KICK_NORMAL] = normal_queue_kick;
				rd_value[`TXPI_KICK_FORCED] = forced_soft_irq;
			end else if (is_idx(cur_idx, `TXPI_IDX_MASK)) begin
				rd_value[`TXPI_EV_W-1:0] = interrupt_enable_mask;
			end else if (is_idx(cur_idx, `TXPI_IDX_STATUS)) begin
				rd_value[`TXPI_EV_W-1:0] = interrupt_event_status;
			end else if (is_idx(cur_idx, `TXPI_IDX_TXCFG)) begin
				rd_value[`TXPI_RETRY_MSB:0] = tx_retry_setting;
			end else if (is_idx(cur_idx, `TXPI_IDX_RXCFG)) begin
				rd_value[`TXPI_ACC_SHORT:0] = receive_config;
			end else if (is_idx(cur_idx, `TXPI_IDX_MISS)) begin
				rd_value[MISS_W-1:0] = miss_bus.count;
			end else if (is_idx(cur_idx, `TXPI_IDX_TIMER)) begin
				rd_value = timer_compare_value;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (state == txpi_pkg::TXPI_READ_WAIT) begin
			hrdata <= rd_value;
		end
	end

	// Queue kicks: a new kick in the drain cycle keeps the bit set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			high_queue_kick <= 1'b0;
			normal_queue_kick <= 1'b0;
		end else begin
			high_queue_kick <= (kick_wr && hwdata[`TXPI_KICK_HIGH]) ||
				(high_queue_kick && !high_queue_drained);
			normal_queue_kick <= (kick_wr && hwdata[`TXPI_KICK_NORMAL]) ||
				(normal_queue_kick && !normal_queue_drained);
		end
	end

	assign soft_kick = kick_wr && hwdata[`TXPI_KICK_FORCED];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			forced_soft_irq <= 1'b0;
		end else begin
			forced_soft_irq <= soft_kick ||
				(forced_soft_irq && interrupt_event_status[`TXPI_EV_SOFT]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interrupt_enable_mask <= `TXPI_EV_RST;
		end else if (mask_wr) begin
			interrupt_enable_mask <= hwdata[`TXPI_EV_W-1:0] & `TXPI_EV_VALID;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_retry_setting <= `TXPI_RETRY_RST;
			receive_config <= `TXPI_ACC_RST;
			timer_compare_value <= `TXPI_TIMER_RST;
		end else if (wr_en) begin
			if (is_idx(cur_idx, `TXPI_IDX_TXCFG)) begin
				tx_retry_setting <= hwdata[`TXPI_RETRY_MSB:0];
			end
			if (is_idx(cur_idx, `TXPI_IDX_RXCFG)) begin
				receive_config <= hwdata[`TXPI_ACC_SHORT:0];
			end
			if (is_idx(cur_idx, `TXPI_IDX_TIMER)) begin
				timer_compare_value <= hwdata;
			end
		end
	end

	// Link pin is asynchronous; only a level on which two stages agree counts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_s1 <= 1'b0;
			link_s2 <= 1'b0;
			link_s3 <= 1'b0;
			link_state <= 1'b0;
		end else begin
			link_s1 <= link_up;
			link_s2 <= link_s1;
			link_s3 <= link_s2;
			if (link_s2 == link_s3) begin
				link_state <= link_s3;
			end
		end
	end

	assign link_state_changed = (link_s2 == link_s3) && (link_s3 != link_state);
	// A compare value of zero leaves the timer event off
	assign timer_hit = (timer_compare_value != `TXPI_TIMER_RST) &&
		(free_running_timer == timer_compare_value);
	always_comb begin
		crc_counts = receive_config[`TXPI_ACC_CRC];
		if (rx_short) begin
			crc_counts = receive_config[`TXPI_ACC_SHORT];
		end else if (rx_runt) begin
			crc_counts = receive_config[`TXPI_ACC_RUNT];
		end
	end

	assign rx_bad_frame = rx_frame_done &&
		(rx_align_error || (rx_crc_error && crc_counts));
	// Retry limit is sixteen collisions times one more than the retry setting
	assign coll_limit = {1'b0, tx_retry_setting, 4'h0} + 9'h010;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coll_count <= 9'h000;
			tx_abort_error <= 1'b0;
		end else begin
			tx_abort_error <= 1'b0;
			if (tx_packet_start) begin
				coll_count <= 9'h000;
			end else if (tx_collision) begin
				if (coll_count + 9'h001 >= coll_limit) begin
					coll_count <= 9'h000;
					tx_abort_error <= 1'b1;
				end else begin
					coll_count <= coll_count + 9'h001;
				end
			end
		end
	end

	always_comb begin
		ev = `TXPI_EV_RST;
		ev[`TXPI_EV_FAULT] = host_bus_fault;
		ev[`TXPI_EV_TIMEOUT] = timer_hit;
		ev[`TXPI_EV_SOFT] = soft_kick;
		ev[`TXPI_EV_TXDESC] = tx_desc_empty;
		ev[`TXPI_EV_OVERRUN] = rx_fifo_overrun;
		ev[`TXPI_EV_LINK] = link_state_changed;
		ev[`TXPI_EV_RXDESC] = rx_desc_empty;
		ev[`TXPI_EV_TXERR] = tx_abort_error;
		ev[`TXPI_EV_TXOK] = tx_done_good;
		ev[`TXPI_EV_RXERR] = rx_bad_frame;
		ev[`TXPI_EV_RXOK] = rx_done_good;
	end

	assign clr = status_wr ? hwdata[`TXPI_EV_W-1:0] : `TXPI_EV_RST;
	// An event in the clearing cycle wins, so no event is lost
	for (genvar i = 0; i < `TXPI_EV_W; i++) begin : g_status
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				interrupt_event_status[i] <= 1'b0;
			end else begin
				interrupt_event_status[i] <= ev[i] ||
					(interrupt_event_status[i] && !clr[i]);
			end
		end
	end

	assign irq = |(interrupt_event_status & interrupt_enable_mask);

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	high_kick_set_a: assert property (
		(kick_wr && hwdata[`TXPI_KICK_HIGH]) |=> high_queue_kick
	) else $error("high queue kick not set by write");
	normal_kick_drain_a: assert property (
		(normal_queue_kick && normal_queue_drained &&
			!(kick_wr && hwdata[`TXPI_KICK_NORMAL])) |=> !normal_queue_kick
	) else $error("normal queue kick not cleared after drain");
	soft_status_set_a: assert property (
		soft_kick |=> (interrupt_event_status[`TXPI_EV_SOFT] && forced_soft_irq)
	) else $error("forced soft irq did not set soft status");
	forced_hold_a: assert property (
		(forced_soft_irq && interrupt_event_status[`TXPI_EV_SOFT]) |=> forced_soft_irq
	) else $error("forced soft irq dropped while soft status set");
	forced_release_a: assert property (
		(forced_soft_irq && !interrupt_event_status[`TXPI_EV_SOFT] && !soft_kick)
		|=> !forced_soft_irq
	) else $error("forced soft irq not released");
	mask_reserved_a: assert property (
		(interrupt_enable_mask & ~`TXPI_EV_VALID) == `TXPI_EV_RST
	) else $error("reserved mask bits set");
	irq_follows_a: assert property (
		mask_wr && (hwdata[`TXPI_EV_W-1:0] & `TXPI_EV_VALID & interrupt_event_status) != 0
		|=> irq
	) else $error("interrupt not raised by enabled status");
	fault_status_a: assert property (
		host_bus_fault |=> interrupt_event_status[`TXPI_EV_FAULT]
	) else $error("host bus fault not recorded");
	timer_status_a: assert property (
		(timer_compare_value != 0 && free_running_timer == timer_compare_value)
		|=> interrupt_event_status[`TXPI_EV_TIMEOUT]
	) else $error("timeout not recorded");
	link_status_a: assert property (
		$changed(link_state) |-> interrupt_event_status[`TXPI_EV_LINK]
	) else $error("link change not recorded");
	abort_status_a: assert property (
		tx_abort_error |=> interrupt_event_status[`TXPI_EV_TXERR]
	) else $error("tx abort not recorded");
	status_clear_a: assert property (
		(status_wr && hwdata[`TXPI_EV_RXOK] && !rx_done_good)
		|=> !interrupt_event_status[`TXPI_EV_RXOK]
	) else $error("status bit not cleared by write of one");
	read_wait_a: assert property (
		(take && !hwrite) |=> !hreadyout ##1 hreadyout
	) else $error("read wait state wrong");
endmodule

// ### verification/tb_txpi_top.sv
`timescale 1ns/100ps

module tb_txpi_top;
	localparam logic [31:0] a_kick = 32'h000000e0;
	localparam logic [31:0] a_mask = 32'h000000f0;
	localparam logic [31:0] a_stat = 32'h000000f8;
	localparam logic [31:0] a_txcf = 32'h00000100;
	localparam logic [31:0] a_rxcf = 32'h00000110;
	localparam logic [31:0] a_miss = 32'h00000130;
	localparam logic [31:0] a_tcmp = 32'h00000170;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic high_queue_kick;
	logic normal_queue_kick;
	logic tx_abort_error;
	// One strobe per event source, pulsed by index
	logic [11:0] ev = 12'h000;
	logic [31:0] tmr = 32'h00000000;
	logic link_up = 1'b0;
	logic crc = 1'b0;
	logic align = 1'b0;
	// Bit 0 runt, bit 1 short
	logic [1:0] rs = 2'h0;
	int mismatches = 0;
	int num_checks = 0;
	int evb[6] = '{15, 7, 6, 4, 2, 0};
	logic [31:0] rx_cfg[5] = '{32'h0, 32'h2, 32'h0, 32'h1, 32'h2};
	// Per case: short, runt, crc, align, then whether an rx error is expected
	logic [4:0] rx_case[5] = '{5'b00100, 5'b00101, 5'b00011, 5'b01101, 5'b10100};

	txpi_top dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.high_queue_drained(ev[6]), .normal_queue_drained(ev[7]),
		.high_queue_kick(high_queue_kick), .normal_queue_kick(normal_queue_kick),
		.host_bus_fault(ev[0]), .free_running_timer(tmr), .tx_desc_empty(ev[1]),
		.rx_fifo_overrun(ev[2]), .rx_packet_dropped(ev[10]), .link_up(link_up),
		.rx_desc_empty(ev[3]), .tx_packet_start(ev[8]), .tx_collision(ev[9]),
		.tx_abort_error(tx_abort_error), .tx_done_good(ev[4]), .rx_frame_done(ev[11]),
		.rx_crc_error(crc), .rx_align_error(align), .rx_runt(rs[0]), .rx_short(rs[1]),
		.rx_done_good(ev[5])
	);

	initial begin
		forever #20 hclk = ~hclk;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Wait for hready sampled high at a rising edge; only the watchdog ends a hang
	task automatic wait_rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			@(posedge hclk);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		hsel <= 1'b1;
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy;
	endtask

	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		hsel <= 1'b1;
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		wait_rdy;
		chk(nm, hrdata, exp);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge hclk);
		ev[i] <= 1'b0;
		@(posedge hclk);
	endtask

	// Level outputs are looked at mid-cycle, once the edge's updates have landed
	task automatic outs(input logic i, input logic hk, input logic nk);
		@(negedge hclk);
		chk("irq", {31'h0, irq}, {31'h0, i});
		chk("high_kick", {31'h0, high_queue_kick}, {31'h0, hk});
		chk("normal_kick", {31'h0, normal_queue_kick}, {31'h0, nk});
		@(posedge hclk);
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		results;
	end

	initial begin
		int b;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		outs(1'b0, 1'b0, 1'b0);
		rdchk("mask_rst", a_mask, 32'h0);
		rdchk("stat_rst", a_stat, 32'h0);
		wr(a_mask, 32'h0000ffff);
		rdchk("mask_rsvd", a_mask, 32'h0000c1ff);
		wr(a_mask | 32'h00000400, 32'h00000000);
		rdchk("mask_far", a_mask, 32'h0000c1ff);
		wr(a_mask, 32'h0);
		rdchk("unmapped", 32'h00000004, 32'h0);
		foreach (evb[k]) begin
			b = evb[k];
			pulse(k);
			outs(1'b0, 1'b0, 1'b0);
			rdchk("ev_set", a_stat, 32'h1 << b);
			wr(a_stat, 32'h0);
			rdchk("w0_keeps", a_stat, 32'h1 << b);
			wr(a_mask, 32'h1 << b);
			outs(1'b1, 1'b0, 1'b0);
			wr(a_stat, 32'h1 << b);
			outs(1'b0, 1'b0, 1'b0);
			rdchk("w1_clears", a_stat, 32'h0);
			wr(a_mask, 32'h0);
		end
		for (int q = 0; q < 2; q++) begin
			wr(a_kick, q == 0 ? 32'h00000080 : 32'h00000040);
			outs(1'b0, q == 0, q == 1);
			wr(a_kick, 32'h0);
			outs(1'b0, q == 0, q == 1);
			pulse(6 + q);
			outs(1'b0, 1'b0, 1'b0);
		end
		wr(a_mask, 32'h00000100);
		wr(a_kick, 32'h00000001);
		outs(1'b1, 1'b0, 1'b0);
		rdchk("soft_stat", a_stat, 32'h00000100);
		wr(a_stat, 32'h0);
		rdchk("forced_held", a_kick, 32'h00000001);
		wr(a_stat, 32'h00000100);
		repeat (2) @(posedge hclk);
		rdchk("forced_auto", a_kick, 32'h0);
		outs(1'b0, 1'b0, 1'b0);
		wr(a_mask, 32'h0);
		wr(a_tcmp, 32'h00000010);
		tmr <= 32'h00000010;
		@(posedge hclk);
		tmr <= 32'h00000011;
		@(posedge hclk);
		rdchk("timeout", a_stat, 32'h00004000);
		wr(a_stat, 32'h0000ffff);
		link_up <= 1'b1;
		repeat (8) @(posedge hclk);
		rdchk("link_rise", a_stat, 32'h00000020);
		wr(a_stat, 32'h0000ffff);
		link_up <= 1'b0;
		repeat (8) @(posedge hclk);
		rdchk("link_fall", a_stat, 32'h00000020);
		wr(a_stat, 32'h0000ffff);
		// Retry setting r gives a limit of 16 * (r + 1) collisions
		for (int r = 0; r < 2; r++) begin
			wr(a_txcf, r);
			pulse(8);
			for (int k = 1; k <= 16 * (r + 1); k++) begin
				ev[9] <= 1'b1;
				@(posedge hclk);
				ev[9] <= 1'b0;
				@(negedge hclk);
				chk("abort", {31'h0, tx_abort_error}, {31'h0, k == 16 * (r + 1)});
				@(posedge hclk);
				if (k == 16 * (r + 1) - 1) begin
					rdchk("no_abort", a_stat, 32'h0);
				end
			end
			@(posedge hclk);
			rdchk("tx_err", a_stat, 32'h00000008);
			wr(a_stat, 32'h0000ffff);
		end
		foreach (rx_case[k]) begin
			wr(a_rxcf, rx_cfg[k]);
			rs <= rx_case[k][4:3];
			crc <= rx_case[k][2];
			align <= rx_case[k][1];
			pulse(11);
			rdchk("rx_err", a_stat, {30'h0, rx_case[k][0], 1'b0});
			wr(a_stat, 32'h0000ffff);
		end
		rs <= 2'h0;
		crc <= 1'b0;
		align <= 1'b0;
		repeat (3) pulse(10);
		rdchk("missed", a_miss, 32'h00000003);
		wr(a_miss, 32'h0);
		rdchk("missed_clr", a_miss, 32'h0);
		results;
	end
endmodule
